// File: common/scip_pkg.sv
/*
   constants and types shared by the process-image device end, the network
   adapter end and the link interface between them.
   assumes a single 10 MHz clock common to both ends.
*/
// How it works
// - two output bytes drive channels 1 to 16
// - six input bytes: status word, then channels
// - status bits 0,1,4,5 used, rest zero
// - config byte 0 picks substitute behaviour
// - config bytes 1-2 give substitute pattern
// - instances 100/193/192 out, 101 in
// - config instance 102, none for listen only
// - channel direction follows its use only
// - output channels mirrored into input image
// - controller never drives a channel used as input
// - ready for connection within 350 ms
// - connection setup finishes within 500 ms
// - listen only must be multicast
package scip_pkg;

   // clock and timing
   localparam int CLK_KHZ      = 10000;
   localparam int READY_MAX_MS = 350;
   localparam int SETUP_MAX_MS = 500;
   localparam int BOOT_US      = 1000;
   localparam int BOOT_CYC     = (BOOT_US * CLK_KHZ) / 1000;
   localparam int SETUP_CYC    = SETUP_MAX_MS * CLK_KHZ;
   localparam int CNT_W        = 24;

   // image widths in bits
   localparam int OUT_W  = 16;
   localparam int IN_W   = 48;
   localparam int CFG_W  = 24;
   localparam int STAT_W = 32;

   // assembly instances
   localparam logic [7:0] INST_OUT_EO = 8'h64;
   localparam logic [7:0] INST_IN     = 8'h65;
   localparam logic [7:0] INST_CFG    = 8'h66;
   localparam logic [7:0] INST_OUT_LO = 8'hC0;
   localparam logic [7:0] INST_OUT_IO = 8'hC1;
   localparam logic [7:0] INST_NONE   = 8'h00;

   // status word bit positions
   localparam int ST_SHORT    = 0;
   localparam int ST_OVLD     = 1;
   localparam int ST_SUP_OVLD = 4;
   localparam int ST_SUP_UV   = 5;

   // adapter register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_OUT    = 8'h04;
   localparam logic [7:0] REG_CFG    = 8'h08;
   localparam logic [7:0] REG_STAT   = 8'h0C;
   localparam logic [7:0] REG_IN_LO  = 8'h10;
   localparam logic [7:0] REG_IN_HI  = 8'h14;
   localparam logic [7:0] REG_IRQ    = 8'h18;
   localparam logic [7:0] REG_MASK   = 8'h1C;

   // control register fields
   localparam int CTRL_OPEN  = 0;
   localparam int CTRL_LOST  = 1;
   localparam int CTRL_TYPE  = 2;
   localparam int CTRL_MCAST = 4;

   // interrupt status bits
   localparam int IRQ_W     = 4;
   localparam int IRQ_UP    = 0;
   localparam int IRQ_REJ   = 1;
   localparam int IRQ_IN    = 2;
   localparam int IRQ_TMO   = 3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      CT_EO = 2'b00,
      CT_IO = 2'b01,
      CT_LO = 2'b10
   } scip_conn_t;

   typedef enum logic [7:0] {
      SV_LOW  = 8'h00,
      SV_HIGH = 8'h01,
      SV_HOLD = 8'h02,
      SV_PAT  = 8'h03
   } scip_subst_t;

   typedef enum logic [0:0] {
      DS_IDLE = 1'b0,
      DS_UP   = 1'b1
   } scip_dstate_t;

endpackage

// File: common/scip_link_if.sv
/*
   link between the adapter end and the process-image device end.
   assumes both ends run on the same clock; no crossing needed.
*/
`timescale 1ns/1ns
interface scip_link_if;
   import scip_pkg::*;

   // connection request from adapter
   logic             conn_req;
   scip_conn_t       conn_type;
   logic             conn_mcast;
   logic [7:0]       out_inst;
   logic [7:0]       in_inst;
   logic [7:0]       cfg_inst;
   logic             conn_lost;
   // cyclic and configuration data from adapter
   logic             out_valid;
   logic [OUT_W-1:0] out_data;
   logic             cfg_valid;
   logic [CFG_W-1:0] cfg_data;
   // answers from device
   logic             dev_ready;
   logic             conn_ack;
   logic             conn_rej;
   logic             conn_up;
   logic [IN_W-1:0]  in_data;
   logic             in_valid;

   modport dev (
      input  conn_req, conn_type, conn_mcast, out_inst, in_inst, cfg_inst, conn_lost,
      input  out_valid, out_data, cfg_valid, cfg_data,
      output dev_ready, conn_ack, conn_rej, conn_up, in_data, in_valid
   );

   modport adp (
      output conn_req, conn_type, conn_mcast, out_inst, in_inst, cfg_inst, conn_lost,
      output out_valid, out_data, cfg_valid, cfg_data,
      input  dev_ready, conn_ack, conn_rej, conn_up, in_data, in_valid
   );
endinterface

// File: logic/scip_device.sv
/*
   process-image device end: maps the cyclic output image onto sixteen
   channel pins, builds the input image from status and channel levels,
   and applies substitute values from owner loss or a fresh owner open until owner data arrives.
   assumes channel and diagnostic pins are asynchronous; link signals
   come from logic on the same clock.
*/
`timescale 1ns/1ns
module scip_device
   import scip_pkg::*;
#(
   parameter int BOOT_CYCLES = BOOT_CYC
) (
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // link to the adapter
   scip_link_if.dev              lk,
   // channel pins, output side
   output wire logic [OUT_W-1:0] chan_out,
   output wire logic [OUT_W-1:0] chan_oe,
   // channel pins, input side
   input  wire logic [OUT_W-1:0] channel_input_line,
   // diagnostic pins
   input  wire logic             out_short,
   input  wire logic             out_ovld,
   input  wire logic             sup_ovld,
   input  wire logic             sup_uv
);

   localparam logic [CNT_W-1:0] BOOT_LAST = CNT_W'(BOOT_CYCLES - 1);

   // whole device state
   typedef struct packed {
      logic [OUT_W-1:0] ch_s1;
      logic [OUT_W-1:0] ch_s2;
      logic [3:0]       dg_s1;
      logic [3:0]       dg_s2;
      logic [CNT_W-1:0] boot_cnt;
      logic             ready;
      scip_dstate_t     st;
      scip_conn_t       ctype;
      logic             ack;
      logic             rej;
      scip_subst_t      mode;
      logic [OUT_W-1:0] pat;
      logic [OUT_W-1:0] out_img;
      logic [OUT_W-1:0] used;
      logic             subst;
      logic [OUT_W-1:0] drive;
      logic [OUT_W-1:0] oe;
      logic [IN_W-1:0]  in_img;
      logic             in_v;
   } scip_dev_t;

   scip_dev_t r;
   scip_dev_t n;

   logic             inst_ok;
   logic             req_ok;
   logic             owner_up;
   logic [OUT_W-1:0] sub_val;
   logic [OUT_W-1:0] mirror;
   logic [STAT_W-1:0] status;

   // instance numbers must match the connection type
   always_comb begin
      case (lk.conn_type)
         CT_EO: inst_ok = lk.out_inst == INST_OUT_EO && lk.cfg_inst == INST_CFG;
         CT_IO: inst_ok = lk.out_inst == INST_OUT_IO && lk.cfg_inst == INST_CFG;
         CT_LO: inst_ok = lk.out_inst == INST_OUT_LO && lk.cfg_inst == INST_NONE;
         default: inst_ok = 1'b0;
      endcase
   end

   // accept only once booted, with the input instance and legal delivery
   assign req_ok = r.ready && inst_ok && lk.in_inst == INST_IN
                   && !(lk.conn_type == CT_LO && !lk.conn_mcast);

   assign owner_up = r.st == DS_UP && r.ctype == CT_EO;

   // substitute value per selected behaviour
   always_comb begin
      case (r.mode)
         SV_LOW:  sub_val = '0;
         SV_HIGH: sub_val = '1;
         SV_HOLD: sub_val = r.out_img;
         SV_PAT:  sub_val = r.pat;
         default: sub_val = '0;
      endcase
   end

   // per channel: driven channels report what they drive, others the pin
   generate
      for (genvar i = 0; i < OUT_W; i++) begin : g_mirror
         assign mirror[i] = r.oe[i] ? r.drive[i] : r.ch_s2[i];
      end
   endgenerate

   // status word, reserved bits zero
   always_comb begin
      status = '0;
      status[ST_SHORT]    = r.dg_s2[0];
      status[ST_OVLD]     = r.dg_s2[1];
      status[ST_SUP_OVLD] = r.dg_s2[2];
      status[ST_SUP_UV]   = r.dg_s2[3];
   end

   // next state
   always_comb begin
      n = r;
      n.ack  = 1'b0;
      n.rej  = 1'b0;

      // pin synchronisers; first stage read only by second
      n.ch_s1 = channel_input_line;
      n.ch_s2 = r.ch_s1;
      n.dg_s1 = {sup_uv, sup_ovld, out_ovld, out_short};
      n.dg_s2 = r.dg_s1;

      // startup delay before connections are taken
      if (!r.ready) begin
         if (r.boot_cnt == BOOT_LAST) begin
            n.ready = 1'b1;
         end else begin
            n.boot_cnt = r.boot_cnt + 1'b1;
         end
      end

      // connection open answers the next cycle, far inside the setup limit
      if (lk.conn_req) begin
         if (req_ok) begin
            n.st    = DS_UP;
            n.ctype = lk.conn_type;
            n.ack   = 1'b1;
            // a fresh owner stays on substitutes until its first data
            if (lk.conn_type == CT_EO) begin
               n.subst = 1'b1;
            end
         end else begin
            n.rej = 1'b1;
         end
      end else if (lk.conn_lost && r.st == DS_UP) begin
         n.st = DS_IDLE;
         if (r.ctype == CT_EO) begin
            n.subst = 1'b1;
         end
      end

      // whole output image taken at once, only from the owner
      if (lk.out_valid && owner_up && !lk.conn_req) begin
         n.out_img = lk.out_data;
         n.used    = r.used | lk.out_data;
         n.subst   = 1'b0;
      end

      // configuration; listen only carries none, bad codes dropped
      if (lk.cfg_valid && r.st == DS_UP && r.ctype != CT_LO
          && lk.cfg_data[7:0] <= SV_PAT) begin
         n.mode = scip_subst_t'(lk.cfg_data[7:0]);
         n.pat  = lk.cfg_data[CFG_W-1:8];
      end

      // one drives on, zero drives off; substitutes while no owner data
      n.drive = r.subst ? sub_val : r.out_img;
      // a channel turns output once its output bit has been used
      n.oe    = r.used;

      // input image: status bytes 0..3, channels in bytes 4 and 5
      n.in_img = {mirror, status};
      n.in_v   = n.in_img != r.in_img;
   end

   // single state register; synchronous reset to all zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // link answers
   assign lk.dev_ready = r.ready;
   assign lk.conn_ack  = r.ack;
   assign lk.conn_rej  = r.rej;
   assign lk.conn_up   = r.st == DS_UP;
   assign lk.in_data   = r.in_img;
   assign lk.in_valid  = r.in_v;

   // pins; used channels stay driven after loss so substitutes reach them
   assign chan_out = r.drive;
   assign chan_oe  = r.oe;

endmodule

// File: logic/scip_adapter.sv
/*
   network adapter end: software opens connections and moves images
   through AXI4-Lite registers; events raise a masked interrupt.
   assumes an AXI4-Lite master on aclk and the device end on the link.
*/
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module scip_adapter
   import scip_pkg::*;
#(
   parameter int SETUP_CYCLES = SETUP_CYC
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // link to the device
   scip_link_if.adp         lk,
   // axi4-lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output wire logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output wire logic        wready,
   output wire logic [1:0]  bresp,
   output wire logic        bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output wire logic        arready,
   output wire logic [31:0] rdata,
   output wire logic [1:0]  rresp,
   output wire logic        rvalid,
   input  wire logic        rready,
   // interrupt
   output wire logic        irq
);

   localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYCLES - 1);

   typedef struct packed {
      logic             aw_ok;
      logic [7:0]       aw_a;
      logic             w_ok;
      logic [31:0]      w_d;
      logic             bv;
      logic [1:0]       br;
      logic             rv;
      logic [31:0]      rd;
      logic [1:0]       rr;
      scip_conn_t       ctype;
      logic             mcast;
      logic             req;
      logic             lost;
      logic             ov;
      logic [OUT_W-1:0] od;
      logic             cv;
      logic [CFG_W-1:0] cd;
      logic [IN_W-1:0]  in_img;
      logic [IRQ_W-1:0] ist;
      logic [IRQ_W-1:0] imask;
      logic             wait_ans;
      logic [CNT_W-1:0] tcnt;
   } scip_adp_t;

   scip_adp_t r;
   scip_adp_t n;
   logic      wr_go;
   logic      rd_go;

   assign wr_go = r.aw_ok && r.w_ok && !r.bv;
   assign rd_go = arvalid && !r.rv;

   always_comb begin
      n = r;
      n.req  = 1'b0;
      n.lost = 1'b0;
      n.ov   = 1'b0;
      n.cv   = 1'b0;

      // address and data taken in either order
      if (awvalid && !r.aw_ok && !r.bv) begin
         n.aw_ok = 1'b1;
         n.aw_a  = awaddr;
      end
      if (wvalid && !r.w_ok && !r.bv) begin
         n.w_ok = 1'b1;
         n.w_d  = wdata;
      end
      if (r.bv && bready) begin
         n.bv = 1'b0;
      end

      // register writes; strobes ignored, whole words only
      if (wr_go) begin
         n.aw_ok = 1'b0;
         n.w_ok  = 1'b0;
         n.bv    = 1'b1;
         n.br    = RESP_OKAY;
         case (r.aw_a)
            REG_CTRL: begin
               n.ctype = scip_conn_t'(r.w_d[CTRL_TYPE +: 2]);
               n.mcast = r.w_d[CTRL_MCAST];
               n.req   = r.w_d[CTRL_OPEN];
               n.lost  = r.w_d[CTRL_LOST] && !r.w_d[CTRL_OPEN];
               if (r.w_d[CTRL_OPEN]) begin
                  n.wait_ans = 1'b1;
                  n.tcnt     = '0;
               end
            end
            REG_OUT: begin
               n.ov = 1'b1;
               n.od = r.w_d[OUT_W-1:0];
            end
            REG_CFG: begin
               n.cv = r.ctype != CT_LO;
               n.cd = r.w_d[CFG_W-1:0];
            end
            REG_MASK: n.imask = r.w_d[IRQ_W-1:0];
            default:  n.br = RESP_SLVERR;
         endcase
      end

      // register reads; reading the interrupt status clears it
      if (r.rv && rready) begin
         n.rv = 1'b0;
      end
      if (rd_go) begin
         n.rv = 1'b1;
         n.rr = RESP_OKAY;
         n.rd = '0;
         case (araddr)
            REG_CTRL:  n.rd = 32'({r.mcast, r.ctype, 2'h0});
            REG_OUT:   n.rd = 32'(r.od);
            REG_CFG:   n.rd = 32'(r.cd);
            REG_STAT:  n.rd = 32'({r.wait_ans, lk.conn_up, lk.dev_ready});
            REG_IN_LO: n.rd = r.in_img[31:0];
            REG_IN_HI: n.rd = 32'(r.in_img[IN_W-1:32]);
            REG_IRQ: begin
               n.rd  = 32'(r.ist);
               n.ist = '0;
            end
            REG_MASK:  n.rd = 32'(r.imask);
            default:   n.rr = RESP_SLVERR;
         endcase
      end

      // setup watchdog; device must answer within the setup limit
      if (r.wait_ans) begin
         if (lk.conn_ack || lk.conn_rej) begin
            n.wait_ans = 1'b0;
         end else if (r.tcnt == SETUP_LAST) begin
            n.wait_ans   = 1'b0;
            n.ist[IRQ_TMO] = 1'b1;
         end else begin
            n.tcnt = r.tcnt + 1'b1;
         end
      end

      // events set after the clear, so a set in the read cycle survives
      if (lk.in_valid) begin
         n.in_img      = lk.in_data;
         n.ist[IRQ_IN] = 1'b1;
      end
      if (lk.conn_ack) begin
         n.ist[IRQ_UP] = 1'b1;
      end
      if (lk.conn_rej) begin
         n.ist[IRQ_REJ] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // bus handshakes
   assign awready = !r.aw_ok && !r.bv;
   assign wready  = !r.w_ok && !r.bv;
   assign bvalid  = r.bv;
   assign bresp   = r.br;
   assign arready = !r.rv;
   assign rvalid  = r.rv;
   assign rdata   = r.rd;
   assign rresp   = r.rr;
   assign irq     = |(r.ist & r.imask);

   // link drive; instance numbers follow the connection type
   assign lk.conn_req   = r.req;
   assign lk.conn_type  = r.ctype;
   assign lk.conn_mcast = r.mcast;
   assign lk.out_inst   = r.ctype == CT_EO ? INST_OUT_EO :
                          r.ctype == CT_IO ? INST_OUT_IO : INST_OUT_LO;
   assign lk.in_inst    = INST_IN;
   assign lk.cfg_inst   = r.ctype == CT_LO ? INST_NONE : INST_CFG;
   assign lk.conn_lost  = r.lost;
   assign lk.out_valid  = r.ov;
   assign lk.out_data   = r.od;
   assign lk.cfg_valid  = r.cv;
   assign lk.cfg_data   = r.cd;

endmodule

// File: tb/scip_link_asserts.sv
/*
   checker for the link between the adapter end and the device end.
   assumes one clock, aresetn synchronous active low, link signals plain.
*/
`timescale 1ns/1ns
module scip_link_asserts
   import scip_pkg::*;
(
   // clock and reset
   input wire logic             aclk,
   input wire logic             aresetn,
   // connection request
   input wire logic             conn_req,
   input wire scip_conn_t       conn_type,
   input wire logic             conn_mcast,
   input wire logic [7:0]       out_inst,
   input wire logic [7:0]       in_inst,
   input wire logic [7:0]       cfg_inst,
   // device answers
   input wire logic             dev_ready,
   input wire logic             conn_ack,
   input wire logic             conn_rej,
   input wire logic             conn_up,
   input wire logic [IN_W-1:0]  in_data
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // exactly one answer per request, one cycle on
   sequence s_ans;
      conn_ack ^ conn_rej;
   endsequence
   sequence s_up;
      ##[0:1] conn_up;
   endsequence

   property p_inst_eo;
      conn_req && conn_type == CT_EO |->
         out_inst == INST_OUT_EO && in_inst == INST_IN && cfg_inst == INST_CFG;
   endproperty
   a_inst_eo: assert property (p_inst_eo) else $error("owner instances off");
   property p_inst_io;
      conn_req && conn_type == CT_IO |->
         out_inst == INST_OUT_IO && in_inst == INST_IN && cfg_inst == INST_CFG;
   endproperty
   a_inst_io: assert property (p_inst_io) else $error("input only instances off");
   property p_inst_lo;
      conn_req && conn_type == CT_LO |->
         out_inst == INST_OUT_LO && in_inst == INST_IN && cfg_inst == INST_NONE;
   endproperty
   a_inst_lo: assert property (p_inst_lo) else $error("listen instances off");
   property p_answer;
      conn_req |=> s_ans;
   endproperty
   a_answer: assert property (p_answer) else $error("request not answered");
   property p_ack_up;
      conn_ack |-> s_up;
   endproperty
   a_ack_up: assert property (p_ack_up) else $error("ack without up");
   property p_lo_mcast;
      conn_req && conn_type == CT_LO && !conn_mcast |=> conn_rej;
   endproperty
   a_lo_mcast: assert property (p_lo_mcast) else $error("listen p2p taken");
   property p_not_ready;
      conn_req && !dev_ready |=> conn_rej && !conn_up;
   endproperty
   a_not_ready: assert property (p_not_ready) else $error("taken before ready");
   property p_ready_stays;
      dev_ready |=> dev_ready;
   endproperty
   a_ready_stays: assert property (p_ready_stays) else $error("ready dropped");
   property p_reserved;
      in_data[31:6] == 26'h0 && in_data[3:2] == 2'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved status set");
endmodule

// File: tb/testbench.sv
/*
   bench joining adapter and device ends; drives the adapter over axi4-lite.
   assumes short boot and setup counts set by parameters below.
*/
`timescale 1ns/1ns
module testbench;
   import scip_pkg::*;

   logic              aclk = 0, aresetn = 0;
   logic [7:0]        awaddr = 0, araddr = 0;
   logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0]       wdata = 0, d;
   logic [1:0]        rsp;
   logic [15:0]       pins = 0;
   logic [3:0]        diag = 0;
   wire logic         awready, wready, bvalid, arready, rvalid, irq;
   wire logic [1:0]   bresp, rresp;
   wire logic [31:0]  rdata;
   wire logic [15:0]  chan_out, chan_oe, channel_input_line;
   int                bad_count = 0, checks = 0, cyc = 0;
   logic [15:0]       exp_sub [4] = '{16'h0000, 16'hFFFF, 16'hA5C3, 16'h1234};
   logic [1:0]        ty [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
   logic              mc [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

   // 100 ns clock
   always #50 aclk = ~aclk;
   // pin level: driven channels show their own drive
   assign channel_input_line = (chan_oe & chan_out) | (~chan_oe & pins);

   scip_link_if lk ();
   scip_device #(.BOOT_CYCLES(8)) u_scip_device (.aclk(aclk), .aresetn(aresetn), .lk(lk),
      .chan_out(chan_out), .chan_oe(chan_oe), .channel_input_line(channel_input_line),
      .out_short(diag[0]), .out_ovld(diag[1]), .sup_ovld(diag[2]), .sup_uv(diag[3]));
   scip_adapter #(.SETUP_CYCLES(64)) u_scip_adapter (.aclk(aclk), .aresetn(aresetn), .lk(lk),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .irq(irq));
   scip_link_asserts u_scip_link_asserts (.aclk(aclk), .aresetn(aresetn),
      .conn_req(lk.conn_req), .conn_type(lk.conn_type), .conn_mcast(lk.conn_mcast),
      .out_inst(lk.out_inst), .in_inst(lk.in_inst), .cfg_inst(lk.cfg_inst),
      .dev_ready(lk.dev_ready), .conn_ack(lk.conn_ack), .conn_rej(lk.conn_rej),
      .conn_up(lk.conn_up), .in_data(lk.in_data));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   // aw and w offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // open request, then let ack and up settle
   task automatic opn(input logic [1:0] t, input logic m);
      wr(REG_CTRL, {27'h0, m, t, 2'b01}, rsp);
      repeat (8) @(posedge aclk);
   endtask

   // hang guard, well above the expected run
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         $display("timeout");
         end_of_test();
      end
   end

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(REG_STAT, d, rsp);
      chk("stat at reset", 48'h0, d);
      // open before boot ends must be refused
      wr(REG_CTRL, 32'h1, rsp);
      repeat (10) @(posedge aclk);
      rd(REG_STAT, d, rsp);
      chk("ready not up", 48'h1, d[2:0]);
      rd(8'h20, d, rsp);
      chk("unmapped resp", RESP_SLVERR, rsp);
      wr(REG_STAT, 32'h0, rsp);
      chk("ro resp", RESP_SLVERR, rsp);
      $display("test access done");
      for (int i = 0; i < 4; i++) begin
         // a refused open keeps the old link, so drop it first
         wr(REG_CTRL, 32'h2, rsp);
         repeat (2) @(posedge aclk);
         opn(ty[i], mc[i]);
         rd(REG_STAT, d, rsp);
         chk("conn up", {47'h0, ~(ty[i] == 2'h2 && !mc[i])}, d[1]);
      end
      $display("test types done");
      for (int c = 0; c < 4; c++) begin
         opn(CT_EO, 1'b0);
         wr(REG_CFG, {8'h00, 16'h1234, 8'(c)}, rsp);
         wr(REG_OUT, 32'h0000A5C3, rsp);
         repeat (8) @(posedge aclk);
         chk("chan_out", 48'hA5C3, chan_out);
         chk("chan_oe", 48'hA5C3, chan_oe);
         if (c == 0) begin
            pins <= 16'h5A3C;
            repeat (8) @(posedge aclk);
            rd(REG_IN_HI, d, rsp);
            chk("in mixed", 48'hFFFF, d);
            pins <= 16'h0000;
            repeat (8) @(posedge aclk);
            rd(REG_IN_HI, d, rsp);
            chk("in mirror", 48'hA5C3, d);
         end
         wr(REG_CTRL, 32'h2, rsp);
         repeat (8) @(posedge aclk);
         chk("substitute", exp_sub[c], chan_out);
      end
      opn(CT_EO, 1'b0);
      wr(REG_CFG, 32'h00000004, rsp);
      wr(REG_CTRL, 32'h2, rsp);
      repeat (8) @(posedge aclk);
      chk("bad code kept", 48'h1234, chan_out);
      $display("test substitute done");
      diag <= 4'hF;
      repeat (8) @(posedge aclk);
      rd(REG_IN_LO, d, rsp);
      chk("status all", 48'h33, d);
      diag <= 4'h1;
      repeat (8) @(posedge aclk);
      rd(REG_IN_LO, d, rsp);
      chk("status short", 48'h01, d);
      $display("test status done");
      rd(REG_IRQ, d, rsp);
      chk("rej event", 48'h1, d[1]);
      wr(REG_MASK, 32'h1, rsp);
      opn(CT_IO, 1'b1);
      chk("irq raised", 48'h1, irq);
      rd(REG_IRQ, d, rsp);
      chk("irq up bit", 48'h1, d[0]);
      repeat (2) @(posedge aclk);
      chk("irq cleared", 48'h0, irq);
      wr(REG_MASK, 32'h0, rsp);
      opn(CT_IO, 1'b1);
      chk("irq masked", 48'h0, irq);
      $display("test irq done");
      end_of_test();
   end
endmodule
